// ### include/gprc_pkg.sv
// Purpose: shared constants and types of the runtime pin settings command block
// Assumes: 32-bit AXI4-Lite register window, byte addresses below
// Notes: report bytes 0-11 are held; bytes 12-63 are reserved and not stored
package gprc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CMD0 = 8'h00; // report bytes 3..0
  localparam logic [7:0] ADDR_CMD1 = 8'h04; // report bytes 7..4
  localparam logic [7:0] ADDR_CMD2 = 8'h08; // report bytes 11..8
  localparam logic [7:0] ADDR_EXEC = 8'h0C;
  localparam logic [7:0] ADDR_RESP0 = 8'h10;
  localparam logic [7:0] ADDR_RESP1 = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_PINS = 8'h1C;
  // command codes and report fields
  localparam logic [7:0] CODE_SET = 8'h60;
  localparam logic [7:0] CODE_GET = 8'h61;
  localparam logic [7:0] STAT_OK = 8'h00;
  localparam logic [7:0] ALTER_ON = 8'h01;
  localparam int IDX_ALTER = 7;
  localparam int IDX_PIN1 = 9;
  localparam int BIT_LEVEL = 4;
  localparam int BIT_DIR = 3;
  localparam logic [7:0] GP_AREA_LEN = 8'h04;
  localparam logic [7:0] CHIP_AREA_LEN = 8'h00; // arbitrary, chip area not held here
  // pin setting after reset: plain I/O, input
  localparam logic [4:0] PIN_RST = 5'h08;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // pin designation codes
  typedef enum logic [2:0] {
    DES_GPIO = 3'h0,
    DES_DED = 3'h1,
    DES_ALT1 = 3'h2,
    DES_ALT2 = 3'h3,
    DES_ALT3 = 3'h4
  } gprc_des_t;
  // highest accepted code, pins one to three
  localparam logic [2:0] DES_MAX [3] = '{3'h4, 3'h3, 3'h3};
  // command sequencer, gray along idle-decode-reply
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DECODE = 2'h1,
    ST_REPLY = 2'h3
  } gprc_state_t;
endpackage : gprc_pkg

// ### logic/gprc_cmd.sv
// Purpose: runtime pin settings commands (set 0x60, get 0x61) over AXI4-Lite
// Assumes: software loads report bytes 0-11, then writes EXEC
// Notes: settings are volatile; nothing here touches stored settings
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gprc_cmd
  import gprc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // general pins
  input wire logic generalPinOneIn,
  output logic generalPinOneOut,
  output logic generalPinOneOeN,
  input wire logic generalPinTwoIn,
  output logic generalPinTwoOut,
  output logic generalPinTwoOeN,
  input wire logic generalPinThreeIn,
  output logic generalPinThreeOut,
  output logic generalPinThreeOeN,
  // alternate function sources
  input wire logic clockRefOut,
  input wire logic serialTxActivityIndicator,
  input wire logic usbConfiguredIndicator,
  input wire logic twowireActivityIndicator,
  // analog switch selects, pins one to three
  output logic [2:0] analogSel
);

  // byte merge under strobes
  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = nw[8*i +: 8];
    return res;
  endfunction : mergeStrb

  // address map check, shared by both channels
  function automatic logic isMapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= ADDR_PINS);
  endfunction : isMapped

  // report byte k from the held words
  function automatic logic [7:0] cmdByte(input logic [31:0] w [3], input int k);
    return w[k / 4][8 * (k % 4) +: 8];
  endfunction : cmdByte

  logic awRdy_reg, awRdy_next, wRdy_reg, wRdy_next;
  logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
  logic [7:0] awAddr_reg, awAddr_next;
  logic [31:0] wData_reg, wData_next;
  logic [3:0] wStrb_reg, wStrb_next;
  logic bValid_reg, bValid_next;
  logic [1:0] bResp_reg, bResp_next;
  logic arRdy_reg, arRdy_next, rValid_reg, rValid_next;
  logic [1:0] rResp_reg, rResp_next;
  logic [31:0] rData_reg, rData_next;
  logic doWrite;
  logic [31:0] cmd_reg [3];
  logic [31:0] cmd_next [3];
  logic [31:0] resp0_reg, resp0_next, resp1_reg, resp1_next;
  logic respValid_reg, respValid_next;
  logic execPulse;
  gprc_state_t state_reg, state_next;
  logic [4:0] pinCfg_reg [3];
  logic [4:0] pinCfg_next [3];
  logic [2:0] pinOut_reg, pinOeN_reg, anaSel_reg, pinIn_reg;
  logic [2:0] drvLevel, drvOeN, drvAna;
  logic [2:0] dedSrc, alt2Src;

  // write channel: address and data taken in either order
  always_comb
  begin
    awHeld_next = awHeld_reg | (s_axi_awvalid & awRdy_reg);
    wHeld_next = wHeld_reg | (s_axi_wvalid & wRdy_reg);
    awAddr_next = (s_axi_awvalid & awRdy_reg) ? s_axi_awaddr : awAddr_reg;
    wData_next = (s_axi_wvalid & wRdy_reg) ? s_axi_wdata : wData_reg;
    wStrb_next = (s_axi_wvalid & wRdy_reg) ? s_axi_wstrb : wStrb_reg;
    bValid_next = bValid_reg & ~s_axi_bready;
    bResp_next = bResp_reg;
    doWrite = 1'b0;
    if (awHeld_next && wHeld_next && !bValid_reg)
    begin
      doWrite = 1'b1;
      awHeld_next = 1'b0;
      wHeld_next = 1'b0;
      bValid_next = 1'b1;
      bResp_next = isMapped(awAddr_next) ? RESP_OKAY : RESP_SLVERR;
    end
    awRdy_next = !awHeld_next && !bValid_next;
    wRdy_next = !wHeld_next && !bValid_next;
  end

  // read channel, one outstanding read
  always_comb
  begin
    rValid_next = rValid_reg & ~s_axi_rready;
    rData_next = rData_reg;
    rResp_next = rResp_reg;
    if (s_axi_arvalid && arRdy_reg)
    begin
      rValid_next = 1'b1;
      rResp_next = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        ADDR_CMD0: rData_next = cmd_reg[0];
        ADDR_CMD1: rData_next = cmd_reg[1];
        ADDR_CMD2: rData_next = cmd_reg[2];
        ADDR_RESP0: rData_next = resp0_reg;
        ADDR_RESP1: rData_next = resp1_reg;
        ADDR_STAT: rData_next = {30'h0000_0000, state_reg != ST_IDLE, respValid_reg};
        ADDR_PINS: rData_next = {29'h0000_0000, pinIn_reg};
        default: rData_next = WORD_RST;
      endcase
    end
    arRdy_next = !rValid_next;
  end

  // bus state registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      awRdy_reg <= 1'b0;
      wRdy_reg <= 1'b0;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= ADDR_CMD0;
      wData_reg <= WORD_RST;
      wStrb_reg <= 4'h0;
      bValid_reg <= 1'b0;
      bResp_reg <= RESP_OKAY;
      arRdy_reg <= 1'b0;
      rValid_reg <= 1'b0;
      rResp_reg <= RESP_OKAY;
      rData_reg <= WORD_RST;
    end
    else
    begin
      awRdy_reg <= awRdy_next;
      wRdy_reg <= wRdy_next;
      awHeld_reg <= awHeld_next;
      wHeld_reg <= wHeld_next;
      awAddr_reg <= awAddr_next;
      wData_reg <= wData_next;
      wStrb_reg <= wStrb_next;
      bValid_reg <= bValid_next;
      bResp_reg <= bResp_next;
      arRdy_reg <= arRdy_next;
      rValid_reg <= rValid_next;
      rResp_reg <= rResp_next;
      rData_reg <= rData_next;
    end
  end

  // command words, exec trigger and the sequencer
  always_comb
  begin
    cmd_next = cmd_reg;
    execPulse = doWrite && awAddr_next == ADDR_EXEC;
    for (int i = 0; i < 3; i++)
      if (doWrite && awAddr_next == ADDR_CMD0 + 8'(4 * i))
        cmd_next[i] = mergeStrb(cmd_reg[i], wData_next, wStrb_next);
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (execPulse) state_next = ST_DECODE; // busy drops exec writes
      ST_DECODE: state_next = ST_REPLY;
      ST_REPLY: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // decode and reply; unknown codes give no reply
  always_comb
  begin
    pinCfg_next = pinCfg_reg;
    resp0_next = resp0_reg;
    resp1_next = resp1_reg;
    respValid_next = respValid_reg;
    if (state_reg == ST_IDLE && execPulse)
      respValid_next = 1'b0;
    if (state_reg == ST_DECODE && cmdByte(cmd_reg, 0) == CODE_SET
        && cmdByte(cmd_reg, IDX_ALTER) == ALTER_ON)
      for (int p = 0; p < 3; p++)
        if ((cmdByte(cmd_reg, IDX_PIN1 + p) & 8'h07) <= 8'(DES_MAX[p]))
          pinCfg_next[p] = 5'(cmdByte(cmd_reg, IDX_PIN1 + p)); // bits 7-5 are don't care
    if (state_reg == ST_REPLY)
    begin
      if (cmdByte(cmd_reg, 0) == CODE_SET)
      begin
        resp0_next = {16'h0000, STAT_OK, CODE_SET};
        respValid_next = 1'b1;
      end
      else if (cmdByte(cmd_reg, 0) == CODE_GET)
      begin
        resp0_next = {GP_AREA_LEN, CHIP_AREA_LEN, STAT_OK, CODE_GET};
        resp1_next = {3'h0, pinCfg_reg[2], 3'h0, pinCfg_reg[1], 3'h0, pinCfg_reg[0], 8'h00};
        respValid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_reg <= '{WORD_RST, WORD_RST, WORD_RST};
      state_reg <= ST_IDLE;
      pinCfg_reg <= '{PIN_RST, PIN_RST, PIN_RST};
      resp0_reg <= WORD_RST;
      resp1_reg <= WORD_RST;
      respValid_reg <= 1'b0;
    end
    else
    begin
      cmd_reg <= cmd_next;
      state_reg <= state_next;
      pinCfg_reg <= pinCfg_next;
      resp0_reg <= resp0_next;
      resp1_reg <= resp1_next;
      respValid_reg <= respValid_next;
    end
  end

  // per-pin role muxes; pin two and three have analog outputs at code 011
  assign dedSrc = {twowireActivityIndicator, usbConfiguredIndicator, clockRefOut};
  assign alt2Src = {1'b0, 1'b0, serialTxActivityIndicator};
  for (genvar g = 0; g < 3; g++)
  begin : g_pin
    gprc_pin_mux #(
      .ALT2_DIGITAL(g == 0)
    ) u_mux (
      .cfg(pinCfg_reg[g]),
      .dedLevel(dedSrc[g]),
      .alt2Level(alt2Src[g]),
      .drvLevel(drvLevel[g]),
      .drvOeN(drvOeN[g]),
      .analogSel(drvAna[g])
    );
  end

  // pin drive registered every cycle, so a new setting shows one cycle after load
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pinOut_reg <= 3'h0;
      pinOeN_reg <= 3'h7;
      anaSel_reg <= 3'h0;
      pinIn_reg <= 3'h0;
    end
    else
    begin
      pinOut_reg <= drvLevel;
      pinOeN_reg <= drvOeN;
      anaSel_reg <= drvAna;
      pinIn_reg <= {generalPinThreeIn, generalPinTwoIn, generalPinOneIn};
    end
  end

  assign s_axi_awready = awRdy_reg;
  assign s_axi_wready = wRdy_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;
  assign s_axi_arready = arRdy_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rresp = rResp_reg;
  assign s_axi_rdata = rData_reg;
  assign generalPinOneOut = pinOut_reg[0];
  assign generalPinOneOeN = pinOeN_reg[0];
  assign generalPinTwoOut = pinOut_reg[1];
  assign generalPinTwoOeN = pinOeN_reg[1];
  assign generalPinThreeOut = pinOut_reg[2];
  assign generalPinThreeOeN = pinOeN_reg[2];
  assign analogSel = anaSel_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_pin1_out;
    pinCfg_reg[0][2:0] == DES_GPIO && !pinCfg_reg[0][BIT_DIR]
      |=> !generalPinOneOeN && generalPinOneOut == $past(pinCfg_reg[0][BIT_LEVEL]);
  endproperty
  a_pin1_out: assert property (p_pin1_out) else $error("pin one output level wrong");

  property p_pin1_in;
    pinCfg_reg[0][2:0] == DES_GPIO && pinCfg_reg[0][BIT_DIR] |=> generalPinOneOeN;
  endproperty
  a_pin1_in: assert property (p_pin1_in) else $error("pin one driven as input");

  property p_pin2_out;
    pinCfg_reg[1][2:0] == DES_GPIO && !pinCfg_reg[1][BIT_DIR]
      |=> !generalPinTwoOeN && generalPinTwoOut == $past(pinCfg_reg[1][BIT_LEVEL]);
  endproperty
  a_pin2_out: assert property (p_pin2_out) else $error("pin two output level wrong");

  property p_pin3_out;
    pinCfg_reg[2][2:0] == DES_GPIO && !pinCfg_reg[2][BIT_DIR]
      |=> !generalPinThreeOeN && generalPinThreeOut == $past(pinCfg_reg[2][BIT_LEVEL]);
  endproperty
  a_pin3_out: assert property (p_pin3_out) else $error("pin three output level wrong");

  property p_bad_code;
    state_reg == ST_DECODE && (cmdByte(cmd_reg, IDX_PIN1) & 8'h07) > 8'(DES_MAX[0]) |=> $stable(pinCfg_reg[0]);
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("pin one took an unused code");

  property p_no_alter;
    state_reg == ST_DECODE && cmdByte(cmd_reg, IDX_ALTER) != ALTER_ON
      |=> $stable(pinCfg_reg[0]) && $stable(pinCfg_reg[1]) && $stable(pinCfg_reg[2]);
  endproperty
  a_no_alter: assert property (p_no_alter) else $error("pins changed without alter");

  property p_set_ack;
    state_reg == ST_DECODE && cmdByte(cmd_reg, 0) == CODE_SET
      |-> ##2 respValid_reg && resp0_reg[15:0] == {STAT_OK, CODE_SET};
  endproperty
  a_set_ack: assert property (p_set_ack) else $error("set reply missing");

  property p_get_ack;
    state_reg == ST_DECODE && cmdByte(cmd_reg, 0) == CODE_GET
      |-> ##2 respValid_reg && resp0_reg == {GP_AREA_LEN, CHIP_AREA_LEN, STAT_OK, CODE_GET};
  endproperty
  a_get_ack: assert property (p_get_ack) else $error("get reply wrong");

  c_set: cover property (state_reg == ST_REPLY && cmdByte(cmd_reg, 0) == CODE_SET);
  c_get: cover property (state_reg == ST_REPLY && cmdByte(cmd_reg, 0) == CODE_GET);
  c_drive: cover property (!generalPinOneOeN ##1 generalPinOneOeN);
endmodule : gprc_cmd
`default_nettype wire

// ### logic/gprc_pin_mux.sv
// Purpose: next drive of one general pin from its runtime settings
// Assumes: combinational; the caller registers all results
// Notes: analog and edge-detect roles release the digital driver
`timescale 1ns/1ps
`default_nettype none
module gprc_pin_mux
  import gprc_pkg::*;
#(
  parameter logic ALT2_DIGITAL = 1'b0
)
(
  // settings
  input wire logic [4:0] cfg,
  // alternate function levels
  input wire logic dedLevel,
  input wire logic alt2Level,
  // pin drive
  output logic drvLevel,
  output logic drvOeN,
  output logic analogSel
);
  // role decode; output enable is active low
  always_comb
  begin
    drvLevel = 1'b0;
    drvOeN = 1'b1;
    analogSel = 1'b0;
    case (cfg[2:0])
      DES_GPIO:
      begin
        drvLevel = cfg[BIT_LEVEL];
        drvOeN = cfg[BIT_DIR];
      end
      DES_DED:
      begin
        drvLevel = dedLevel;
        drvOeN = 1'b0;
      end
      DES_ALT1: analogSel = 1'b1;
      DES_ALT2:
      begin
        // analog output owns the pin unless the role is digital
        if (ALT2_DIGITAL)
        begin
          drvLevel = alt2Level;
          drvOeN = 1'b0;
        end
        else
        begin
          analogSel = 1'b1;
        end
      end
      default: ; // edge detection only listens
    endcase
  end
endmodule : gprc_pin_mux
`default_nettype wire

// ### tb/gprc_pin_env.sv
// Purpose: outside world of the three general pins
// Assumes: the outside drives a released pin with extLevel
// Notes: no pull on these pins, so a released pin shows only the outside level
`timescale 1ns/1ps
`default_nettype none
module gprc_pin_env
(
  // design drive, enable active low
  input wire logic [2:0] drvLevel,
  input wire logic [2:0] drvOeN,
  // outside drive and resolved wire
  input wire logic [2:0] extLevel,
  output logic [2:0] wireLevel
);
  // contention is not modelled; the design wins while it drives
  always_comb wireLevel = (~drvOeN & drvLevel) | (drvOeN & extLevel);
endmodule : gprc_pin_env
`default_nettype wire

// ### tb/test_gp_pin_runtime_config_cmd.sv
// Purpose: self-checking bench of the runtime pin settings commands
// Assumes: AXI4-Lite master tasks, bready and rready held high throughout
// Notes: pin expectations come from a shadow copy of the pin settings
`timescale 1ns/1ps
`default_nettype none
module test_gp_pin_runtime_config_cmd;
  import gprc_pkg::*;
  logic clk, srst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, lfsrVal;
  logic [3:0] wstrb, src;
  logic [1:0] bresp, rresp;
  logic [2:0] pOut, pOeN, pIn, ext, analogSel, expWire;
  logic [4:0] cfg [3];
  int errCount, numChecks;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  gprc_cmd gprc_cmd_i (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .generalPinOneIn(pIn[0]), .generalPinOneOut(pOut[0]), .generalPinOneOeN(pOeN[0]),
    .generalPinTwoIn(pIn[1]), .generalPinTwoOut(pOut[1]), .generalPinTwoOeN(pOeN[1]),
    .generalPinThreeIn(pIn[2]), .generalPinThreeOut(pOut[2]), .generalPinThreeOeN(pOeN[2]),
    .clockRefOut(src[0]), .usbConfiguredIndicator(src[1]), .twowireActivityIndicator(src[2]),
    .serialTxActivityIndicator(src[3]), .analogSel(analogSel));

  gprc_pin_env gprc_pin_env_i (.drvLevel(pOut), .drvOeN(pOeN), .extLevel(ext), .wireLevel(pIn));

  // repeatable random source
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return (x >> 1) ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction : lfsr

  task automatic end_sim();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!bvalid && n < 50);
    if (!bvalid)
    begin
      errCount++;
      end_sim();
    end
    else
    begin
      r = bresp;
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!rvalid && n < 50);
    if (!rvalid)
    begin
      errCount++;
      end_sim();
    end
    else
    begin
      d = rdata;
      r = rresp;
    end
  endtask : axi_rd

  // load report bytes 0-11, start, poll for the reply
  task automatic run_cmd(input logic [31:0] w0, w1, w2, output logic ok);
    logic [31:0] d;
    logic [1:0] r;
    ok = 1'b0;
    axi_wr(ADDR_CMD0, w0, r);
    axi_wr(ADDR_CMD1, w1, r);
    axi_wr(ADDR_CMD2, w2, r);
    axi_wr(ADDR_EXEC, 32'h0000_0001, r);
    chk(r, RESP_OKAY);
    for (int n = 0; n < 8 && !ok; n++)
    begin
      axi_rd(ADDR_STAT, d, r);
      ok = d[0];
    end
  endtask : run_cmd

  task automatic chk_pins();
    logic [2:0] c;
    logic oe, lvl;
    logic [31:0] d;
    logic [1:0] r;
    for (int p = 0; p < 3; p++)
    begin
      c = cfg[p][2:0];
      oe = (c == 3'h0 && !cfg[p][3]) || c == 3'h1 || (c == 3'h3 && p == 0);
      lvl = c == 3'h0 ? cfg[p][4] : (c == 3'h1 ? src[p] : src[3]);
      chk(pOeN[p], !oe);
      if (oe) chk(pOut[p], lvl);
      chk(analogSel[p], c == 3'h2 || (c == 3'h3 && p > 0));
      expWire[p] = oe ? lvl : ext[p];
    end
    axi_rd(ADDR_PINS, d, r);
    chk(d[2:0], expWire);
  endtask : chk_pins

  task automatic chk_get();
    logic ok;
    logic [31:0] d;
    logic [1:0] r;
    run_cmd({24'h0, CODE_GET}, 32'h0, 32'h0, ok);
    chk(ok, 1'b1);
    axi_rd(ADDR_RESP0, d, r);
    chk(r, RESP_OKAY);
    chk(d, {GP_AREA_LEN, CHIP_AREA_LEN, STAT_OK, CODE_GET});
    axi_rd(ADDR_RESP1, d, r);
    chk(d, {3'h0, cfg[2], 3'h0, cfg[1], 3'h0, cfg[0], 8'h00});
  endtask : chk_get

  // main sequence
  initial
  begin
    logic ok;
    logic [31:0] d;
    logic [7:0] b, alter;
    logic [1:0] r;
    clk = 1'b0;
    srst = 1'b1;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    ext = 3'h5;
    src = 4'h0;
    lfsrVal = 32'h0753_6716;
    errCount = 0;
    numChecks = 0;
    for (int p = 0; p < 3; p++) cfg[p] = PIN_RST;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({pOeN, pOut, analogSel}, 9'h1C0);
    chk_get();
    $display("test reset done");
    // every role code on every pin, then random bytes and alter values
    for (int i = 0; i < 24; i++)
    begin
      lfsrVal = lfsr(lfsrVal);
      d = lfsrVal;
      src <= d[31:28];
      ext <= d[27:25];
      alter = (i < 8 || d[24]) ? ALTER_ON : 8'h02;
      for (int p = 0; p < 3; p++)
      begin
        b = (i < 8) ? {d[p*8+:5], i[2:0]} : d[p*8+:8];
        d[p*8+:8] = b;
        if (alter == ALTER_ON && b[2:0] <= DES_MAX[p]) cfg[p] = b[4:0];
      end
      run_cmd({24'h0, CODE_SET}, {alter, 24'h0}, {d[23:0], 8'h00}, ok);
      chk(ok, 1'b1);
      axi_rd(ADDR_RESP0, d, r);
      chk(d[15:0], {STAT_OK, CODE_SET});
      chk_pins();
      if (i % 6 == 5) chk_get();
    end
    $display("test set commands done");
    // reset in mid-run must return every pin to plain input
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int p = 0; p < 3; p++) cfg[p] = PIN_RST;
    chk({pOeN, pOut, analogSel}, 9'h1C0);
    chk_get();
    $display("test mid-run reset done");
    // unknown command code gets no reply; read and write at unmapped 0x40 get SLVERR
    run_cmd(32'h0000_0062, 32'h0, 32'h0, ok);
    chk(ok, 1'b0);
    axi_rd(8'h40, d, r);
    chk(r, RESP_SLVERR);
    axi_wr(8'h40, 32'h0, r);
    chk(r, RESP_SLVERR);
    $display("test refusals done");
    end_sim();
  end
endmodule : test_gp_pin_runtime_config_cmd
`default_nettype wire
